// ---- hw/saesl_consts.svh ----
// Offsets, field positions and reset values for the secondary error severity and log block.
// Assumes inclusion by the package and by the block's single design file.
`ifndef SAESL_CONSTS_SVH
`define SAESL_CONSTS_SVH
`define SAESL_OFF_SEVERITY  12'h134
`define SAESL_OFF_CAPCTL    12'h138
`define SAESL_OFF_LOG0      12'h13c
`define SAESL_OFF_LOG1      12'h140
`define SAESL_OFF_LOG2      12'h144
`define SAESL_OFF_LOG3      12'h148
`define SAESL_SEV_RESET     32'h00001340
`define SAESL_SEV_WMASK     32'h00003fee
`define SAESL_ERR_LIVE      32'h00001e8c
`define SAESL_CAP_RESET     32'h00000000
`define SAESL_PTR_MSB       4
`define SAESL_LOWER_CMD_LSB 36
`define SAESL_UPPER_CMD_LSB 40
`define SAESL_ADDR_LO_LSB   64
`define SAESL_ADDR_HI_LSB   96
`endif

// ---- hw/saesl_pkg.sv ----
// Types shared by the secondary error severity and log block.
// Assumes the constants header sits beside it on the include path.
package saesl_pkg;
  `include "saesl_consts.svh"
  typedef logic [31:0]  saesl_word_t;   // One configuration dword.
  typedef logic [11:0]  saesl_off_t;    // Extended configuration offset.
  typedef logic [4:0]   saesl_ptr_t;    // First error bit position.
  typedef logic [127:0] saesl_log_t;    // Captured header log.
endpackage

// ---- hw/saesl_secondary_aer_severity_log.sv ----
// Secondary-side severity select, first error pointer and header log registers.
// Assumes a configuration access port that presents one dword per cycle and an
// external detector that gives one-cycle error pulses with the cycle's address phases.
`include "saesl_consts.svh"

module saesl_secondary_aer_severity_log (
  input  wire logic               mclk,          // 200 MHz clock.
  input  wire logic               rst_n,         // Fundamental reset, active low, synchronous.
  input  wire logic               cfgWrEn,       // Configuration write strobe, one cycle.
  input  wire saesl_pkg::saesl_off_t  cfgAddr,   // Configuration offset of the access.
  input  wire saesl_pkg::saesl_word_t cfgWrData, // Configuration write data.
  output logic [31:0]             cfgRdData,     // Registered read data for cfgAddr.
  input  wire logic [31:0]        errDetect,     // Error pulses by status bit position.
  input  wire logic [31:0]        errMask,       // Mask register value from outside.
  input  wire logic               firstErrArm,   // Pointer may load (no error pending).
  input  wire logic [31:0]        addrPhase1,    // AD during first address phase.
  input  wire logic [31:0]        addrPhase2,    // AD during second address phase.
  input  wire logic [3:0]         cmdPhase1,     // C/BE during first address phase.
  input  wire logic [3:0]         cmdPhase2,     // C/BE during second address phase.
  input  wire logic               dualAddr,      // The cycle used a dual address.
  output logic                    errFatalMsg,   // Send fatal message, one-cycle pulse.
  output logic                    errNonfatalMsg,// Send nonfatal message, one-cycle pulse.
  output logic [31:0]             statusSet      // Status bits to set, one-cycle pulse.
);
  import saesl_pkg::*;

  //--------------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------------
  saesl_word_t sev_q,   sev_d;    // Severity select register.
  saesl_ptr_t  ptr_q,   ptr_d;    // First error pointer.
  saesl_log_t  log_q,   log_d;    // Header log.
  saesl_word_t rd_q,    rd_d;     // Read data register.
  logic        fat_q,   fat_d;    // Fatal message pulse.
  logic        nfat_q,  nfat_d;   // Nonfatal message pulse.
  saesl_word_t stat_q,  stat_d;   // Status set pulse.
  saesl_word_t live;              // Unmasked errors this cycle.
  saesl_ptr_t  firstIdx;          // Lowest unmasked error position.

  // Lowest set bit of a vector; ties in one cycle go to the lowest position.
  function automatic saesl_ptr_t lowest_bit(input saesl_word_t v);
    lowest_bit = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        lowest_bit = 5'(i);
      end
    end
  endfunction

  // Only the seven error classes that a conventional PCI secondary bus can raise
  // count here. The PCI-X positions are dropped on purpose, so that the severity
  // bits stored for them can never steer a message, the status or the pointer.
  assign live     = errDetect & ~errMask & `SAESL_ERR_LIVE;
  // Ties within one cycle resolve to the lowest position.
  assign firstIdx = lowest_bit(live);

  //--------------------------------------------------------------------------
  // Next-state logic
  //--------------------------------------------------------------------------
  // Writes, capture and messages. PCI-X bits are stored but never reach the
  // message path, because live never carries those positions.
  // Every next value but rd_d gets a default before any branch, and rd_d has a case default, so no path leaves a latch.
  always_comb begin
    sev_d  = sev_q;
    ptr_d  = ptr_q;
    log_d  = log_q;
    stat_d = live;
    fat_d  = |(live & sev_q);
    nfat_d = |(live & ~sev_q);
    // Writes to any other offset, the read-only ones included, are dropped.
    if (cfgWrEn && cfgAddr == `SAESL_OFF_SEVERITY) begin
      // Reserved positions are cut here, so they can never read back as one.
      sev_d = cfgWrData & `SAESL_SEV_WMASK;
    end
    // A new unmasked error overwrites the whole log, the upper phase too,
    // so a stale dual-address entry never survives a single-address one.
    if (|live) begin
      log_d = '0;
      log_d[`SAESL_ADDR_LO_LSB +: 32] = addrPhase1;
      log_d[`SAESL_ADDR_HI_LSB +: 32] = dualAddr ? addrPhase2 : 32'h00000000;
      log_d[`SAESL_LOWER_CMD_LSB +: 4] = cmdPhase1;
      log_d[`SAESL_UPPER_CMD_LSB +: 4] = dualAddr ? cmdPhase2 : 4'h0;
      // The pointer only moves while no earlier error is pending in status.
      if (firstErrArm) begin
        ptr_d = firstIdx;
      end
    end
    // Read data is registered, so it answers the offset of the previous cycle.
    unique case (cfgAddr)
      `SAESL_OFF_SEVERITY: rd_d = sev_q & `SAESL_SEV_WMASK;
      `SAESL_OFF_CAPCTL:   rd_d = {27'h0000000, ptr_q};
      `SAESL_OFF_LOG0:     rd_d = log_q[31:0];
      `SAESL_OFF_LOG1:     rd_d = log_q[63:32];
      `SAESL_OFF_LOG2:     rd_d = log_q[95:64];
      `SAESL_OFF_LOG3:     rd_d = log_q[127:96];
      default:             rd_d = 32'h00000000;            // Unmapped reads zero.
    endcase
  end

  //--------------------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------------------
  // Only the fundamental reset reaches this process; hot resets do not.
  // The reset is synchronous, so a glitch between edges cannot clear state.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sev_q  <= `SAESL_SEV_RESET;
      ptr_q  <= 5'h00;
      log_q  <= '0;
      rd_q   <= 32'h00000000;
      fat_q  <= 1'b0;
      nfat_q <= 1'b0;
      stat_q <= 32'h00000000;
    end else begin
      sev_q  <= sev_d;
      ptr_q  <= ptr_d;
      log_q  <= log_d;
      rd_q   <= rd_d;
      fat_q  <= fat_d;
      nfat_q <= nfat_d;
      stat_q <= stat_d;
    end
  end

  // Outputs are the registers themselves, with no logic behind the flops.
  assign cfgRdData      = rd_q;
  assign errFatalMsg    = fat_q;
  assign errNonfatalMsg = nfat_q;
  assign statusSet      = stat_q;

  //--------------------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------------------
  // Every check but the reset one is held off while the reset is applied.

  // An unmasked error whose severity bit is set leaves as a fatal message.
  a_fatal_class: assert property (@(posedge mclk) disable iff (!rst_n)
    |(errDetect & ~errMask & sev_q & 32'h00001e8c) |=> errFatalMsg)
    else $error("fatal error not reported as fatal");

  // A cleared severity bit turns the same error into a nonfatal message.
  a_nonfatal_class: assert property (@(posedge mclk) disable iff (!rst_n)
    |(errDetect & ~errMask & ~sev_q & 32'h00001e8c) |=> errNonfatalMsg)
    else $error("nonfatal error not reported as nonfatal");

  // The first edge after release must see the default severities.
  a_sev_reset: assert property (@(posedge mclk) rst_n && $past(!rst_n) |->
    sev_q == 32'h00001340)
    else $error("severity reset value wrong");

  // Reserved severity positions never hold a one.
  a_sev_reserved: assert property (@(posedge mclk) disable iff (!rst_n)
    (sev_q & 32'hffffc011) == 32'h0)
    else $error("reserved severity bit set");

  // A PCI-X severity bit keeps what software wrote.
  a_sev_store: assert property (@(posedge mclk) disable iff (!rst_n)
    cfgWrEn && cfgAddr == 12'h134 |=> sev_q[13] == $past(cfgWrData[13]))
    else $error("PCI-X severity write lost");

  // Without an unmasked error of an implemented class nothing is reported.
  a_pcix_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    (errDetect & ~errMask & 32'h00001e8c) == 32'h0 |=>
      statusSet == 32'h0 && !errFatalMsg && !errNonfatalMsg)
    else $error("unimplemented error position reported");

  // A severity read returns the register with its reserved bits at zero.
  a_sev_read: assert property (@(posedge mclk) disable iff (!rst_n)
    cfgAddr == 12'h134 |=> cfgRdData == $past(sev_q) && cfgRdData[31:14] == 18'h0)
    else $error("severity read wrong");

  // The capability register shows only the pointer.
  a_cap_read: assert property (@(posedge mclk) disable iff (!rst_n)
    cfgAddr == 12'h138 |=> cfgRdData[31:5] == 27'h0 && cfgRdData[4:0] == $past(ptr_q))
    else $error("capability read wrong");

  // Masked errors leave the log and the message outputs alone.
  a_masked_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    (errDetect & ~errMask) == 32'h0 |=> $stable(log_q) && !errFatalMsg && !errNonfatalMsg)
    else $error("masked error had an effect");

  // The pointer stays put unless an armed, unmasked error arrives.
  a_ptr_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    !(|live && firstErrArm) |=> $stable(ptr_q))
    else $error("pointer moved without an armed error");

  // Every unmasked error recaptures the first phase and its command.
  a_log_capture: assert property (@(posedge mclk) disable iff (!rst_n)
    |live |=> log_q[95:64] == $past(addrPhase1) && log_q[39:36] == $past(cmdPhase1))
    else $error("log capture wrong");

  // A single address leaves the upper phase at zero.
  a_log_layout: assert property (@(posedge mclk) disable iff (!rst_n)
    |live && !dualAddr |=> log_q[127:96] == 32'h0 && log_q[95:64] == $past(addrPhase1))
    else $error("log layout wrong");

  // A dual address fills the upper phase and the upper command.
  a_log_dual: assert property (@(posedge mclk) disable iff (!rst_n)
    |live && dualAddr |=> log_q[127:96] == $past(addrPhase2) &&
      log_q[43:40] == $past(cmdPhase2))
    else $error("dual address log wrong");

  // The attribute and reserved fields of the log stay at zero.
  a_log_zeros: assert property (@(posedge mclk) disable iff (!rst_n)
    log_q[63:44] == 20'h0 && log_q[35:0] == 36'h0)
    else $error("log reserved bits set");

  // Pointer and status move together, so software sees one snapshot.
  a_ptr_sync: assert property (@(posedge mclk) disable iff (!rst_n)
    |live && firstErrArm |=> statusSet[ptr_q] && statusSet != 32'h0)
    else $error("pointer not updated with status");

  // The lowest log dword answers its own offset.
  a_log_read0: assert property (@(posedge mclk) disable iff (!rst_n)
    cfgAddr == 12'h13c |=> cfgRdData == $past(log_q[31:0]))
    else $error("log dword0 read wrong");

  // The second log dword answers its own offset.
  a_log_read1: assert property (@(posedge mclk) disable iff (!rst_n)
    cfgAddr == 12'h140 |=> cfgRdData == $past(log_q[63:32]))
    else $error("log dword1 read wrong");

  // The third log dword answers its own offset.
  a_log_read2: assert property (@(posedge mclk) disable iff (!rst_n)
    cfgAddr == 12'h144 |=> cfgRdData == $past(log_q[95:64]))
    else $error("log dword2 read wrong");

  // The top log dword answers its own offset.
  a_log_read: assert property (@(posedge mclk) disable iff (!rst_n)
    cfgAddr == 12'h148 |=> cfgRdData == $past(log_q[127:96]))
    else $error("log dword3 read wrong");
endmodule

// ---- sim/saesl_err_source.sv ----
// Model of the secondary bus error detector that feeds the block.
// Assumes the bench asks for one error event at a time, each in its own cycle.
module saesl_err_source (
  input  wire logic        mclk,       // Block clock.
  input  wire logic        fire,       // Request for one error pulse.
  input  wire logic [4:0]  bitNo,      // Status bit position to pulse.
  input  wire logic [31:0] adr,        // Address of the failing cycle.
  input  wire logic        dual,       // The failing cycle used two address phases.
  output logic [31:0]      errDetect,  // One-cycle error pulses.
  output logic [31:0]      addrPhase1, // First address phase.
  output logic [31:0]      addrPhase2, // Second address phase.
  output logic [3:0]       cmdPhase1,  // First command nibble.
  output logic [3:0]       cmdPhase2,  // Second command nibble.
  output logic             dualAddr    // Dual address flag.
);
  timeunit 1ns;
  timeprecision 1ps;
  // Outside a pulse the first phase, its command and the dual flag invert each cycle, so a late capture is seen.
  always @(posedge mclk) begin
    errDetect  <= fire ? (32'h1 << bitNo) : 32'h0;
    addrPhase1 <= fire ? adr : ~addrPhase1;
    addrPhase2 <= ~adr;
    cmdPhase1  <= fire ? adr[3:0] : ~cmdPhase1;
    cmdPhase2  <= adr[7:4];
    dualAddr   <= fire ? dual : ~dualAddr;
  end
endmodule

// ---- sim/test_secondary_aer_severity_log.sv ----
// Self-checking bench for the severity select, pointer and header log block.
// Assumes the detector model drives the error side and the bench the config side.
module test_secondary_aer_severity_log;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst_n = 1'b0, cfgWrEn = 1'b0, firstErrArm = 1'b1, fire = 1'b0, dual = 1'b0;
  logic [11:0] cfgAddr = 12'h0;
  logic [31:0] cfgWrData = 32'h0, errMask = 32'h0, adr = 32'h0, cfgRdData, errDetect, statusSet;
  logic [31:0] addrPhase1, addrPhase2;
  logic [4:0] bitNo = 5'h0;
  logic [3:0] cmdPhase1, cmdPhase2;
  logic dualAddr, errFatalMsg, errNonfatalMsg;
  int mismatches = 0, comparisons = 0, cycles = 0;
  always #2.5 mclk = ~mclk;
  saesl_err_source saesl_err_source_i (.mclk(mclk), .fire(fire), .bitNo(bitNo), .adr(adr),
    .dual(dual), .errDetect(errDetect), .addrPhase1(addrPhase1), .addrPhase2(addrPhase2),
    .cmdPhase1(cmdPhase1), .cmdPhase2(cmdPhase2), .dualAddr(dualAddr));
  saesl_secondary_aer_severity_log saesl_secondary_aer_severity_log_i (.mclk(mclk),
    .rst_n(rst_n), .cfgWrEn(cfgWrEn), .cfgAddr(cfgAddr), .cfgWrData(cfgWrData),
    .cfgRdData(cfgRdData), .errDetect(errDetect), .errMask(errMask),
    .firstErrArm(firstErrArm), .addrPhase1(addrPhase1), .addrPhase2(addrPhase2),
    .cmdPhase1(cmdPhase1), .cmdPhase2(cmdPhase2), .dualAddr(dualAddr),
    .errFatalMsg(errFatalMsg), .errNonfatalMsg(errNonfatalMsg), .statusSet(statusSet));
  task chk(input string n, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk) begin cfgWrEn <= 1'b1; cfgAddr <= a; cfgWrData <= d; end
    @(posedge mclk) cfgWrEn <= 1'b0;
  endtask
  // Read data arrives one edge after the address is presented.
  task rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge mclk) cfgAddr <= a;
    @(posedge mclk) #1;
    chk("cfgRdData", cfgRdData, e);
  endtask
  task ev(input logic [4:0] b, input logic [31:0] a, input logic d, f);
    @(posedge mclk) begin bitNo <= b; adr <= a; dual <= d; fire <= 1'b1; end
    @(posedge mclk) fire <= 1'b0;
    @(posedge mclk) #1;
    chk("statusSet", statusSet, errMask[b] ? 32'h0 : 32'h1 << b);
    chk("errFatalMsg", {31'h0, errFatalMsg}, {31'h0, f & ~errMask[b]});
    chk("errNonfatalMsg", {31'h0, errNonfatalMsg}, {31'h0, ~f & ~errMask[b]});
  endtask
  task lg(input logic [31:0] a, input logic d);
    rd(12'h13c, 32'h0);
    rd(12'h140, {20'h0, d ? a[7:4] : 4'h0, a[3:0], 4'h0});
    rd(12'h144, a);
    rd(12'h148, d ? ~a : 32'h0);
  endtask
  task tRegs;
    rd(12'h134, 32'h00001340);
    rd(12'h138, 32'h0);
    lg(32'h0, 1'b0);
    wr(12'h134, 32'hffffffff);
    rd(12'h134, 32'h00003fee);
    wr(12'h138, 32'hffffffff);
    rd(12'h138, 32'h0);
    wr(12'h134, 32'h00001340);
    $display("registers done");
  endtask
  task tEvents;
    ev(5'd12, 32'hc0de_5a17, 1'b0, 1'b1);
    rd(12'h138, 32'd12);
    lg(32'hc0de_5a17, 1'b0);
    ev(5'd11, 32'h1234_56a9, 1'b1, 1'b0);
    lg(32'h1234_56a9, 1'b1);
    @(posedge mclk) firstErrArm <= 1'b0;
    ev(5'd3, 32'h0bad_0f03, 1'b0, 1'b0);
    rd(12'h138, 32'd11);
    // Only the PCI-X positions set: every real class must stay nonfatal.
    wr(12'h134, 32'h00002162);
    rd(12'h134, 32'h00002162);
    ev(5'd2, 32'h7777_1111, 1'b0, 1'b0);
    wr(12'h134, 32'hffffffff);
    ev(5'd7, 32'h2222_3333, 1'b0, 1'b1);
    $display("events done");
  endtask
  task tMask;
    @(posedge mclk) begin errMask <= 32'h00000200; firstErrArm <= 1'b1; end
    ev(5'd9, 32'h4444_5555, 1'b0, 1'b1);
    lg(32'h2222_3333, 1'b0);
    rd(12'h138, 32'd11);
    $display("mask done");
  endtask
  // A mid-run fundamental reset must bring every sticky field back to default.
  task tReset;
    @(posedge mclk) rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd(12'h134, 32'h00001340);
    rd(12'h138, 32'h0);
    lg(32'h0, 1'b0);
    $display("reset done");
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // The whole sequence needs well under a thousand cycles.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      conclude;
    end
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    tRegs;
    tEvents;
    tMask;
    tReset;
    conclude;
  end
endmodule
